//--- core/bdrst_ctrl.v
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "bdrst_map.vh"

module bdrst_ctrl #(
  parameter SEQ_CYCLES = `BDRST_SEQ_CYCLES,
  parameter FILTER_CYCLES = `BDRST_FILTER_CYCLES
) (
  input wire REF_CLK,
  input wire RST_N,
  input wire HSEL,
  input wire [7:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output wire HREADYOUT,
  output wire HRESP,
  input wire RESET_INPUT_PIN_I,
  output wire RESET_INPUT_PIN_O,
  output reg RESET_INPUT_PIN_OE_N,
  output reg RESET_INDICATION_OUTPUT_N,
  output reg CORE_RESET_N,
  input wire WDT_RESET_REQ,
  input wire [`BDRST_PORT_WIDTH-1:0] LOWER_DATA_PORT_I,
  output reg [`BDRST_PORT_WIDTH-1:0] LOWER_DATA_PORT_CFG,
  output reg BOOT_LOADER_ENTER
);

  // ==========================================================================
  // Sequencer states
  localparam [2:0] ST_SEQ = 3'b001;
  localparam [2:0] ST_INIT = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  localparam [1:0] SRC_HW = 2'h0;
  localparam [1:0] SRC_SW = 2'h1;
  localparam [1:0] SRC_WDT = 2'h2;

  // ==========================================================================
  // Reset release and pin synchronisers
  reg rst_meta_n;
  reg rst_sync_n;

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  reg pin_meta;
  reg pin_sync;
  reg [`BDRST_PORT_WIDTH-1:0] port_meta;
  reg [`BDRST_PORT_WIDTH-1:0] port_sync;

  always @(posedge REF_CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      port_meta <= `BDRST_PORT_RESET;
      port_sync <= `BDRST_PORT_RESET;
    end else begin
      pin_meta <= RESET_INPUT_PIN_I;
      pin_sync <= pin_meta;
      port_meta <= LOWER_DATA_PORT_I;
      port_sync <= port_meta;
    end
  end

  // ==========================================================================
  // Control state
  reg [2:0] state;
  reg [1:0] source;
  reg bidir_active;
  reg bidir_reset_enable;
  reg init_done;
  reg [3:0] flags;
  reg [`BDRST_PORT_WIDTH-1:0] port_cfg;

  wire st_seq = state[0];
  wire st_init = state[1];
  wire st_run = state[2];

  // ==========================================================================
  // Reset pin filter and internal sequence timer
  wire hw_detect;
  wire seq_done;

  // The filter restarts while the sequence runs, so our own pull-down seen
  // through the synchroniser after release cannot raise a second reset.
  wire filter_clear = pin_sync | st_seq;

  // Without bidirectional mode a held pin stretches a pin-triggered sequence; with it the
  // pin reads our own drive and must not hold the timer.
  wire pin_holds = st_seq & ~bidir_active & (source == SRC_HW) & ~pin_sync;
  wire seq_clear = ~st_seq | pin_holds;

  bdrst_timer #(
    .WIDTH(8),
    .LIMIT(FILTER_CYCLES)
  ) u_filter (
    .clk(REF_CLK),
    .rst_n(rst_sync_n),
    .clear(filter_clear),
    .done(hw_detect)
  );

  bdrst_timer #(
    .WIDTH(16),
    .LIMIT(SEQ_CYCLES)
  ) u_seq (
    .clk(REF_CLK),
    .rst_n(rst_sync_n),
    .clear(seq_clear),
    .done(seq_done)
  );

  // ==========================================================================
  // AHB-Lite slave, zero wait states, always OKAY
  reg dp_write;
  reg [7:0] dp_addr;

  wire ap_valid = HSEL & HREADY & HTRANS[1];

  always @(posedge REF_CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_write <= ap_valid & HWRITE;
      dp_addr <= HADDR;
    end
  end

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  wire ctl_write = dp_write & (dp_addr == `BDRST_OFS_CONTROL);
  wire wr_enable = ctl_write & ~init_done & ~st_seq;
  wire wr_end_init = ctl_write & HWDATA[`BDRST_CTL_END_INIT] & st_init;
  wire wr_swrst = ctl_write & HWDATA[`BDRST_CTL_SWRST] & (st_init | st_run);

  wire [31:0] status_word = {25'h0000000, pin_sync, bidir_active, init_done, flags};
  wire [31:0] portcfg_word = {23'h000000, BOOT_LOADER_ENTER, port_cfg};

  always @(posedge REF_CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      HRDATA <= 32'h00000000;
    end else if (ap_valid & ~HWRITE) begin
      case (HADDR)
        `BDRST_OFS_CONTROL: HRDATA <= {31'h00000000, bidir_reset_enable};
        `BDRST_OFS_STATUS: HRDATA <= status_word;
        `BDRST_OFS_PORTCFG: HRDATA <= portcfg_word;
        default: HRDATA <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // Reset sequencer
  wire trig_hw = ~st_seq & hw_detect;
  wire trig_sw = wr_swrst;
  wire trig_wdt = ~st_seq & WDT_RESET_REQ;
  wire trigger = trig_hw | trig_sw | trig_wdt;

  reg [2:0] next_state;

  always @* begin
    next_state = state;
    case (state)
      ST_SEQ: begin
        if (seq_done) begin
          next_state = ST_INIT;
        end
      end
      ST_INIT: begin
        if (trigger) begin
          next_state = ST_SEQ;
        end else if (wr_end_init) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (trigger) begin
          next_state = ST_SEQ;
        end
      end
      default: next_state = ST_SEQ;
    endcase
  end

  always @(posedge REF_CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ST_SEQ;
      source <= SRC_HW;
      bidir_active <= 1'b0;
      bidir_reset_enable <= 1'b0;
      init_done <= 1'b0;
    end else begin
      state <= next_state;
      if (trigger) begin
        // The mode in force when the reset hits governs that whole reset.
        bidir_active <= bidir_reset_enable;
        bidir_reset_enable <= 1'b0;
        init_done <= 1'b0;
        if (trig_hw) begin
          source <= SRC_HW;
        end else if (trig_wdt) begin
          source <= SRC_WDT;
        end else begin
          source <= SRC_SW;
        end
      end else begin
        if (wr_enable) begin
          bidir_reset_enable <= HWDATA[`BDRST_CTL_ENABLE];
        end
        if (st_init & wr_end_init) begin
          init_done <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Reset source flags and port configuration latch
  wire seq_end = st_seq & seq_done;
  wire latch_port = bidir_active | (source == SRC_HW);

  always @(posedge REF_CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flags <= `BDRST_FLAGS_RESET;
      port_cfg <= `BDRST_PORT_RESET;
      LOWER_DATA_PORT_CFG <= `BDRST_PORT_RESET;
      BOOT_LOADER_ENTER <= 1'b0;
    end else if (seq_end) begin
      flags <= 4'h0;
      if (bidir_active) begin
        flags[`BDRST_STS_HW_LONG] <= 1'b1;
      end else begin
        case (source)
          SRC_HW: begin
            // A pin still low when the sequence ends makes a long reset.
            flags[`BDRST_STS_HW_LONG] <= ~pin_sync;
            flags[`BDRST_STS_HW_SHORT] <= pin_sync;
          end
          SRC_SW: flags[`BDRST_STS_SW] <= 1'b1;
          SRC_WDT: flags[`BDRST_STS_WDT] <= 1'b1;
          default: flags[`BDRST_STS_HW_LONG] <= 1'b1;
        endcase
      end
      if (latch_port) begin
        port_cfg <= port_sync;
        LOWER_DATA_PORT_CFG <= port_sync;
        BOOT_LOADER_ENTER <= ~port_sync[`BDRST_CFG_BOOT_BIT];
      end
    end
  end

  // ==========================================================================
  // Pin and reset outputs
  // The pin is only ever pulled low, never driven high, so it can share the
  // line with open-drain reset devices on the board.
  assign RESET_INPUT_PIN_O = 1'b0;

  always @(posedge REF_CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      RESET_INPUT_PIN_OE_N <= 1'b1;
      RESET_INDICATION_OUTPUT_N <= 1'b0;
      CORE_RESET_N <= 1'b0;
    end else begin
      RESET_INPUT_PIN_OE_N <= ~(next_state[0] & (trigger ? bidir_reset_enable : bidir_active));
      RESET_INDICATION_OUTPUT_N <= next_state[2];
      CORE_RESET_N <= ~next_state[0];
    end
  end

endmodule // bdrst_ctrl

`default_nettype wire

//--- core/bdrst_map.vh
`ifndef BDRST_MAP_VH
`define BDRST_MAP_VH

// ==========================================================================
// Register offsets (byte addresses on the AHB-Lite port)
`define BDRST_OFS_CONTROL 8'h00
`define BDRST_OFS_STATUS 8'h04
`define BDRST_OFS_PORTCFG 8'h08

// ==========================================================================
// Control register fields
`define BDRST_CTL_ENABLE 0
`define BDRST_CTL_END_INIT 1
`define BDRST_CTL_SWRST 2

// ==========================================================================
// Status register fields
`define BDRST_STS_HW_LONG 0
`define BDRST_STS_HW_SHORT 1
`define BDRST_STS_SW 2
`define BDRST_STS_WDT 3
`define BDRST_STS_INIT_DONE 4
`define BDRST_STS_BIDIR 5
`define BDRST_STS_PIN 6

// ==========================================================================
// Port configuration register fields
`define BDRST_CFG_BOOT_BIT 4
`define BDRST_CFG_BOOT_FLAG 8
`define BDRST_PORT_WIDTH 8
`define BDRST_PORT_RESET 8'hff

// ==========================================================================
// Reset values and timing
`define BDRST_FLAGS_RESET 4'h1
`define BDRST_CLK_PERIOD_PS 4000
`define BDRST_FILTER_NS 100
`define BDRST_FILTER_CYCLES ((`BDRST_FILTER_NS * 1000 + `BDRST_CLK_PERIOD_PS - 1) / `BDRST_CLK_PERIOD_PS)
`define BDRST_SEQ_CYCLES 1024

`endif

//--- core/bdrst_timer.v
`timescale 1ns/1ps
`default_nettype none

module bdrst_timer #(
  parameter WIDTH = 11,
  parameter LIMIT = 1024
) (
  input wire clk,
  input wire rst_n,
  input wire clear,
  output reg done
);

  localparam integer LAST_INT = LIMIT - 2;
  localparam [WIDTH-1:0] LAST = LAST_INT[WIDTH-1:0];

  reg [WIDTH-1:0] count;

  // Done rises LIMIT-1 edges after clear drops and then holds, so a state left on done lasts LIMIT cycles.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {WIDTH{1'b0}};
      done <= 1'b0;
    end else if (clear) begin
      count <= {WIDTH{1'b0}};
      done <= 1'b0;
    end else if (!done) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
      done <= (count == LAST);
    end
  end

endmodule // bdrst_timer

`default_nettype wire

//--- sim/bdrst_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bdrst_monitor #(
  parameter int SEQ_CYCLES = 1024,
  parameter int FILTER_CYCLES = 25
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic RESET_INPUT_PIN_I,
  input wire logic RESET_INPUT_PIN_O,
  input wire logic RESET_INPUT_PIN_OE_N,
  input wire logic RESET_INDICATION_OUTPUT_N,
  input wire logic CORE_RESET_N,
  input wire logic WDT_RESET_REQ,
  input wire logic [7:0] LOWER_DATA_PORT_CFG,
  input wire logic BOOT_LOADER_ENTER
);
  // ==========
  // Run-length counters
  int oe_cnt;
  int core_cnt;
  int low_cnt;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      oe_cnt <= 0;
      core_cnt <= 0;
      low_cnt <= 0;
    end else begin
      oe_cnt <= RESET_INPUT_PIN_OE_N ? 0 : oe_cnt + 1;
      core_cnt <= CORE_RESET_N ? 0 : core_cnt + 1;
      low_cnt <= RESET_INPUT_PIN_I ? 0 : (low_cnt < 255 ? low_cnt + 1 : low_cnt);
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // ==========
  // Checks
  a_pin_in_seq: assert property (!RESET_INPUT_PIN_OE_N |-> !CORE_RESET_N && !RESET_INPUT_PIN_O)
    else $error("pin driven outside sequence");
  a_pin_with_seq: assert property ($fell(RESET_INPUT_PIN_OE_N) |-> $fell(CORE_RESET_N))
    else $error("pin pull not at sequence start");
  a_pin_full_seq: assert property ($rose(RESET_INPUT_PIN_OE_N) |-> oe_cnt >= SEQ_CYCLES)
    else $error("pin released early");
  a_core_full_seq: assert property ($rose(CORE_RESET_N) |-> core_cnt >= SEQ_CYCLES)
    else $error("sequence too short");
  a_ind_in_seq: assert property (!CORE_RESET_N |-> !RESET_INDICATION_OUTPUT_N)
    else $error("indication high in sequence");
  a_ind_held: assert property ($rose(CORE_RESET_N) |-> !RESET_INDICATION_OUTPUT_N [*3])
    else $error("indication rose without end of init");
  a_pin_resets: assert property (low_cnt == FILTER_CYCLES + 4 |-> !CORE_RESET_N)
    else $error("low pin did not reset");
  a_wdt_resets: assert property (WDT_RESET_REQ && CORE_RESET_N |-> ##[1:4] !CORE_RESET_N)
    else $error("watchdog did not reset");
  a_cfg_at_end: assert property (!$stable(LOWER_DATA_PORT_CFG) |-> !$past(CORE_RESET_N, 2))
    else $error("port config changed outside reset");
  a_boot_of_cfg: assert property (BOOT_LOADER_ENTER == !LOWER_DATA_PORT_CFG[4])
    else $error("boot select disagrees with port");
endmodule // bdrst_monitor
bind bdrst_ctrl bdrst_monitor #(
  .SEQ_CYCLES(SEQ_CYCLES),
  .FILTER_CYCLES(FILTER_CYCLES)
) u_mon (
  .REF_CLK(REF_CLK),
  .RST_N(RST_N),
  .RESET_INPUT_PIN_I(RESET_INPUT_PIN_I),
  .RESET_INPUT_PIN_O(RESET_INPUT_PIN_O),
  .RESET_INPUT_PIN_OE_N(RESET_INPUT_PIN_OE_N),
  .RESET_INDICATION_OUTPUT_N(RESET_INDICATION_OUTPUT_N),
  .CORE_RESET_N(CORE_RESET_N),
  .WDT_RESET_REQ(WDT_RESET_REQ),
  .LOWER_DATA_PORT_CFG(LOWER_DATA_PORT_CFG),
  .BOOT_LOADER_ENTER(BOOT_LOADER_ENTER)
);
`default_nettype wire

//--- sim/bdrst_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module bdrst_pin_model (
  input wire logic ext_low,
  input wire logic oe_n,
  input wire logic o,
  output logic pin
);
  // ==========
  // Open-drain line with pull-up: either side can only pull low.
  assign pin = !(ext_low || (!oe_n && !o));
endmodule // bdrst_pin_model
`default_nettype wire

//--- sim/bidirectional_reset_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bidirectional_reset_control_tb;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic hwrite = 1'h0;
  logic wdt = 1'h0;
  logic ext = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] haddr = 8'h00;
  logic [7:0] port = 8'hff;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rdv;
  logic [8:0] ecfg = 9'h0ff;
  wire [31:0] hrdata;
  wire [7:0] cfg;
  wire hready, pin, pin_o, oe_n, ind_n, core_n, boot, hresp;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  bdrst_ctrl #(.SEQ_CYCLES(16)) dut (
    .REF_CLK(clk), .RST_N(rst_n), .HSEL(1'h1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .RESET_INPUT_PIN_I(pin), .RESET_INPUT_PIN_O(pin_o), .RESET_INPUT_PIN_OE_N(oe_n),
    .RESET_INDICATION_OUTPUT_N(ind_n), .CORE_RESET_N(core_n), .WDT_RESET_REQ(wdt),
    .LOWER_DATA_PORT_I(port), .LOWER_DATA_PORT_CFG(cfg), .BOOT_LOADER_ENTER(boot)
  );
  bdrst_pin_model u_pin (.ext_low(ext), .oe_n(oe_n), .o(pin_o), .pin(pin));
  // ==========
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (!hready);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (!hready);
    rdv = hrdata;
    chk("hresp", 32'h0, hresp);
  endtask
  task complete_run;
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Source s: 0 pin, 1 software, 2 watchdog; the pin pulse is kept short on purpose.
  task automatic run(input int s, input logic b);
    logic seen;
    logic [7:0] pv;
    pv = b ? 8'hef : 8'h5a;
    port <= pv;
    bus(1'h1, 8'h00, {31'h0, b});
    bus(1'h1, 8'h00, {30'h0, 1'h1, b});
    repeat (2) @(posedge clk);
    chk("ind_run", 1'h1, ind_n);
    bus(1'h1, 8'h00, {31'h0, !b});
    bus(1'h0, 8'h00, 32'h0);
    chk("en_lock", b, rdv[0]);
    if (s == 0) ext <= 1'h1;
    if (s == 1) bus(1'h1, 8'h00, 32'h4);
    if (s == 2) wdt <= 1'h1;
    while (core_n) @(posedge clk);
    repeat (4) @(posedge clk);
    ext <= 1'h0;
    wdt <= 1'h0;
    seen = 1'h0;
    while (!core_n) begin
      @(posedge clk);
      seen |= !oe_n;
    end
    chk("pin_pull", b, seen);
    chk("ind_rst", 1'h0, ind_n);
    bus(1'h0, 8'h04, 32'h0);
    chk("flags", b ? 4'h1 : 4'h2 << s, rdv[3:0]);
    chk("bidir", b, rdv[5]);
    bus(1'h0, 8'h00, 32'h0);
    chk("en_clr", 1'h0, rdv[0]);
    if (b || s == 0) ecfg = {!pv[4], pv};
    bus(1'h0, 8'h08, 32'h0);
    chk("portcfg", ecfg, rdv[8:0]);
    chk("cfg_out", ecfg, {boot, cfg});
  endtask
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    while (!core_n) @(posedge clk);
    chk("ind_pwr", 1'h0, ind_n);
    chk("oe_pwr", 1'h1, oe_n);
    bus(1'h0, 8'h00, 32'h0);
    chk("en_pwr", 1'h0, rdv[0]);
    for (int b = 0; b < 2; b++)
      for (int s = 0; s < 3; s++)
        run(s, b[0]);
    complete_run();
  end
endmodule // bidirectional_reset_control_tb
`default_nettype wire
